/* bench/lcd_cpu16_host_port_test.sv */
module lcd_cpu16_host_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        req_valid = 1'b0;
  logic [1:0]  req_op = 2'h0;
  logic        req_pixel = 1'b0;
  logic [15:0] req_data = 16'h0000;
  logic        dev_reset_req = 1'b0;
  logic        dev_sleep_out = 1'b0;
  logic        req_ready, rsp_valid, lcd_reset_n, lcd_cs_n, sel, lcd_wr_n, lcd_rd_n;
  logic        host_oe, dev_oe;
  logic [15:0] rsp_data, host_o, dev_o, bus, cmd_q, data_q;
  logic [7:0]  rst_low;
  int          failures = 0;
  int          compares = 0;
  int          rsp_n = 0;
  // Pull-up on the shared bus when nobody drives it
  assign bus = host_oe ? host_o : (dev_oe ? dev_o : 16'hFFFF);
  initial forever #4 clk = ~clk;
  always @(posedge clk) if (rsp_valid === 1'b1) rsp_n++;
  lhp_host #(.RESET_LOW_CYC(10), .WAIT_IN_CYC(20), .WAIT_OUT_CYC(30)) i_lhp_host (
    .clk, .reset, .req_valid, .req_op, .req_pixel, .req_data, .dev_reset_req,
    .dev_sleep_out, .req_ready, .rsp_valid, .rsp_data, .lcd_reset_n, .lcd_cs_n,
    .lcd_cmd_data_select(sel), .lcd_wr_n, .lcd_rd_n, .host_data_bus_i(bus),
    .host_data_bus_o(host_o), .host_data_bus_oe(host_oe));
  lhp_dev_model i_lhp_dev_model (.clk, .reset_n(lcd_reset_n), .cs_n(lcd_cs_n),
    .sel, .wr_n(lcd_wr_n), .rd_n(lcd_rd_n), .bus, .dev_o, .dev_oe, .cmd_q,
    .data_q, .rst_low_q(rst_low));
  task automatic finish_test;
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  task automatic cyc;
    @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_ready(output int c);
    c = 0;
    while (req_ready !== 1'b1 && c < 5000) begin
      cyc();
      c++;
    end
    if (c >= 5000) begin
      failures++;
      $display("CHECK FAILED at %0t: ready never came", $time);
    end
  endtask : wait_ready
  task automatic req(input logic [1:0] op, input logic px, input logic [15:0] d);
    int c;
    wait_ready(c);
    req_op = op;
    req_pixel = px;
    req_data = d;
    req_valid = 1'b1;
    cyc();
    req_valid = 1'b0;
    wait_ready(c);
  endtask : req
  task automatic dev_reset(input logic so, input int min_cyc);
    int c;
    dev_sleep_out = so;
    dev_reset_req = 1'b1;
    cyc();
    dev_reset_req = 1'b0;
    wait_ready(c);
    chk({8'h00, rst_low}, 16'h000A);
    chk(c >= min_cyc, 16'h0001);
    req(2'h0, 1'b0, {15'h0000, so});
    chk(cmd_q, {15'h0000, so});
  endtask : dev_reset
  task automatic write_scenario;
    req(2'h0, 1'b0, 16'h002C);
    chk(cmd_q, 16'h002C);
    req(2'h1, 1'b1, 16'hF81F);
    chk(data_q, 16'hF81F);
    req(2'h1, 1'b0, 16'h07E1);
    chk(data_q, 16'h07E1);
    chk({15'h0000, lcd_cs_n}, 16'h0001);
    chk({15'h0000, host_oe}, 16'h0000);
  endtask : write_scenario
  task automatic read_scenario;
    req(2'h0, 1'b0, 16'h002E);
    req(2'h2, 1'b0, 16'h0000);
    chk(rsp_n, 16'h0000);
    req(2'h2, 1'b0, 16'h0000);
    chk(rsp_n, 16'h0001);
    chk(rsp_data, 16'h1234);
    chk({15'h0000, lcd_cs_n}, 16'h0001);
  endtask : read_scenario
  initial begin
    repeat (12) @(posedge clk);
    #1;
    reset = 1'b0;
    write_scenario();
    read_scenario();
    dev_reset(1'b1, 40);
    dev_reset(1'b0, 30);
    finish_test();
  end
  initial begin
    #50000;
    failures++;
    finish_test();
  end
endmodule : lcd_cpu16_host_port_test

/* bench/lhp_dev_model.sv */
module lhp_dev_model (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        cs_n,
  input  wire logic        sel,
  input  wire logic        wr_n,
  input  wire logic        rd_n,
  input  wire logic [15:0] bus,
  output logic      [15:0] dev_o,
  output logic             dev_oe,
  output logic      [15:0] cmd_q,
  output logic      [15:0] data_q,
  output logic      [7:0]  rst_low_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_n_q;
  logic reset_n_q;
  logic dummy_q;
  assign dev_oe = !cs_n && !rd_n;
  // Dummy word differs from real data so a kept dummy shows up
  assign dev_o = dummy_q ? 16'hA5A5 : 16'h1234;
  always_ff @(posedge clk) begin
    rd_n_q <= rd_n;
    reset_n_q <= reset_n;
  end
  // Length of the last low pulse on the reset pin
  always_ff @(posedge clk) begin
    if (reset_n_q && !reset_n) begin
      rst_low_q <= 8'h01;
    end else if (!reset_n && rst_low_q != 8'hFF) begin
      rst_low_q <= rst_low_q + 8'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dummy_q <= 1'b1;
    end else if (!cs_n && !wr_n) begin
      if (sel) begin
        data_q <= bus;
      end else begin
        cmd_q <= bus;
        dummy_q <= 1'b1;
      end
    end else if (!cs_n && !rd_n_q && rd_n && sel) begin
      dummy_q <= 1'b0;
    end
  end
endmodule : lhp_dev_model

/* common/lhp_pkg.sv */
package lhp_pkg;
  localparam int CLK_PERIOD_NS = 8;
  // Reset pulse and completion times
  localparam int RESET_LOW_MIN_US          = 10;
  localparam int RESET_COMPLETE_SLEEP_IN_MS  = 5;
  localparam int RESET_COMPLETE_SLEEP_OUT_MS = 120;
  localparam int RESET_LOW_CYCLES =
    (RESET_LOW_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_WAIT_IN_CYCLES =
    (RESET_COMPLETE_SLEEP_IN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_WAIT_OUT_CYCLES =
    (RESET_COMPLETE_SLEEP_OUT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Strobe timing: low and high phase lengths in ns, rounded up to cycles
  localparam int WR_LOW_NS  = 15;
  localparam int WR_HIGH_NS = 50;
  localparam int RD_LOW_NS  = 355;
  localparam int RD_HIGH_NS = 95;
  localparam int WR_LOW_CYCLES  = (WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_HIGH_CYCLES = (WR_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_LOW_CYCLES  = (RD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_HIGH_CYCLES = (RD_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_W = 16;
  localparam int CNT_W  = 25;
  // 5-6-5 pixel field positions
  localparam int RED_LSB   = 11;
  localparam int GREEN_LSB = 5;
  localparam int BLUE_LSB  = 0;
  typedef enum logic [1:0] {
    LHP_OP_CMD,
    LHP_OP_WRITE,
    LHP_OP_READ
  } lhp_op_e;
endpackage : lhp_pkg

/* rtl/lhp_host.sv */
module lhp_host #(
  parameter int RESET_LOW_CYC  = lhp_pkg::RESET_LOW_CYCLES,
  parameter int WAIT_IN_CYC    = lhp_pkg::RESET_WAIT_IN_CYCLES,
  parameter int WAIT_OUT_CYC   = lhp_pkg::RESET_WAIT_OUT_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        req_valid,
  input  wire logic [1:0]  req_op,
  input  wire logic        req_pixel,
  input  wire logic [15:0] req_data,
  input  wire logic        dev_reset_req,
  input  wire logic        dev_sleep_out,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic [15:0]      rsp_data,
  output logic             lcd_reset_n,
  output logic             lcd_cs_n,
  output logic             lcd_cmd_data_select,
  output logic             lcd_wr_n,
  output logic             lcd_rd_n,
  input  wire logic [15:0] host_data_bus_i,
  output logic [15:0]      host_data_bus_o,
  output logic             host_data_bus_oe
);
  typedef enum logic [2:0] {
    ST_RST_LOW, ST_RST_WAIT, ST_IDLE, ST_LOW, ST_HIGH
  } lhp_state_e;

  lhp_state_e         state_q;
  logic [24:0]        cnt_q;
  logic               is_read_q;
  logic               dummy_pend_q;
  logic               wait_out_q;
  logic [15:0]        wdata;

  // Pixel mode packs all 16 bits unchanged as 5-6-5 fields; raw words otherwise
  function automatic logic [15:0] pack565(input logic [15:0] d);
    return {d[15:11], d[10:5], d[4:0]};
  endfunction : pack565

  assign wdata = req_pixel ? pack565(req_data) : req_data;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q             <= ST_RST_LOW;
      cnt_q               <= '0;
      is_read_q           <= 1'b0;
      dummy_pend_q        <= 1'b0;
      wait_out_q          <= 1'b0;
      req_ready           <= 1'b0;
      rsp_valid           <= 1'b0;
      rsp_data            <= 16'h0000;
      lcd_reset_n         <= 1'b0;
      lcd_cs_n            <= 1'b1;
      lcd_cmd_data_select <= 1'b1;
      lcd_wr_n            <= 1'b1;
      lcd_rd_n            <= 1'b1;
      host_data_bus_o     <= 16'h0000;
      host_data_bus_oe    <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      unique case (state_q)
        ST_RST_LOW: begin
          lcd_reset_n <= 1'b0;
          if (cnt_q == 25'(RESET_LOW_CYC - 1)) begin
            lcd_reset_n <= 1'b1;
            cnt_q       <= '0;
            state_q     <= ST_RST_WAIT;
          end else begin
            cnt_q <= cnt_q + 25'h0000001;
          end
        end
        ST_RST_WAIT: begin
          if (cnt_q == (wait_out_q ? 25'(WAIT_OUT_CYC - 1)
                                   : 25'(WAIT_IN_CYC - 1))) begin
            cnt_q     <= '0;
            req_ready <= 1'b1;
            state_q   <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 25'h0000001;
          end
        end
        ST_IDLE: begin
          if (dev_reset_req) begin
            req_ready   <= 1'b0;
            wait_out_q  <= dev_sleep_out;
            lcd_reset_n <= 1'b0;
            cnt_q       <= '0;
            state_q     <= ST_RST_LOW;
          end else if (req_valid) begin
            req_ready           <= 1'b0;
            lcd_cs_n            <= 1'b0;
            lcd_cmd_data_select <= (req_op != 2'(lhp_pkg::LHP_OP_CMD));
            is_read_q           <= (req_op == 2'(lhp_pkg::LHP_OP_READ));
            if (req_op == 2'(lhp_pkg::LHP_OP_READ)) begin
              lcd_rd_n         <= 1'b0;
              host_data_bus_oe <= 1'b0;
            end else begin
              lcd_wr_n         <= 1'b0;
              host_data_bus_o  <= wdata;
              host_data_bus_oe <= 1'b1;
            end
            // A new index arms the dummy read discard
            if (req_op == 2'(lhp_pkg::LHP_OP_CMD)) begin
              dummy_pend_q <= 1'b1;
            end
            cnt_q   <= '0;
            state_q <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (cnt_q == (is_read_q ? 25'(lhp_pkg::RD_LOW_CYCLES - 1)
                                  : 25'(lhp_pkg::WR_LOW_CYCLES - 1))) begin
            lcd_wr_n <= 1'b1;
            lcd_rd_n <= 1'b1;
            cnt_q    <= '0;
            state_q  <= ST_HIGH;
            if (is_read_q) begin
              if (dummy_pend_q) begin
                dummy_pend_q <= 1'b0;
              end else begin
                rsp_valid <= 1'b1;
                rsp_data  <= host_data_bus_i;
              end
            end
          end else begin
            cnt_q <= cnt_q + 25'h0000001;
          end
        end
        ST_HIGH: begin
          host_data_bus_oe <= 1'b0;
          if (cnt_q == (is_read_q ? 25'(lhp_pkg::RD_HIGH_CYCLES - 1)
                                  : 25'(lhp_pkg::WR_HIGH_CYCLES - 1))) begin
            lcd_cs_n  <= 1'b1;
            cnt_q     <= '0;
            req_ready <= 1'b1;
            state_q   <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 25'h0000001;
          end
        end
        default: state_q <= ST_RST_LOW;
      endcase
    end
  end

  a_bus_off_read: assert property (@(posedge clk) disable iff (reset)
    !lcd_rd_n |-> !host_data_bus_oe) else $error("host drives bus during read");
  a_bus_on_write: assert property (@(posedge clk) disable iff (reset)
    !lcd_wr_n |-> host_data_bus_oe) else $error("bus not driven during write");
  a_write_data_hold: assert property (@(posedge clk) disable iff (reset)
    !lcd_wr_n && $past(!lcd_wr_n) |-> $stable(host_data_bus_o)) else $error("write data moved");
  a_cs_strobes: assert property (@(posedge clk) disable iff (reset)
    (!lcd_wr_n || !lcd_rd_n) |-> !lcd_cs_n) else $error("strobe without chip select");
  a_select_stable: assert property (@(posedge clk) disable iff (reset)
    $fell(lcd_wr_n) || $fell(lcd_rd_n) |=> $stable(lcd_cmd_data_select)
    ) else $error("select moved during strobe");
  a_no_reads_idx: assert property (@(posedge clk) disable iff (reset)
    $fell(lcd_rd_n) |-> lcd_cmd_data_select) else $error("read with index select");
  a_reset_width: assert property (@(posedge clk) disable iff (reset)
    $fell(lcd_reset_n) |=> !lcd_reset_n [*8]) else $error("reset pulse too short");
  a_ready_in_rst: assert property (@(posedge clk) disable iff (reset)
    !lcd_reset_n |-> !req_ready) else $error("ready while device in reset");
  a_wait_after: assert property (@(posedge clk) disable iff (reset)
    $rose(lcd_reset_n) |-> !req_ready [*8]) else $error("ready too soon after reset");
  a_dummy_drop: assert property (@(posedge clk) disable iff (reset)
    state_q == ST_LOW && is_read_q && dummy_pend_q |=> !rsp_valid) else $error("dummy returned");

  // Checker helpers: low length of the reset pin and time since it rose, both saturating
  logic [24:0]        rst_low_len_q;
  logic [24:0]        since_rst_q;

  always_ff @(posedge clk) begin
    if (reset || lcd_reset_n) begin
      rst_low_len_q <= '0;
    end else if (rst_low_len_q != '1) begin
      rst_low_len_q <= rst_low_len_q + 25'h0000001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !lcd_reset_n) begin
      since_rst_q <= '0;
    end else if (since_rst_q != '1) begin
      since_rst_q <= since_rst_q + 25'h0000001;
    end
  end

  a_reset_long: assert property (@(posedge clk) disable iff (reset)
    $rose(lcd_reset_n) |-> rst_low_len_q >= 25'(RESET_LOW_CYC)
    ) else $error("reset pulse under minimum");
  a_ready_wait: assert property (@(posedge clk) disable iff (reset)
    $rose(req_ready) |-> since_rst_q >= (wait_out_q ? 25'(WAIT_OUT_CYC) : 25'(WAIT_IN_CYC))
    ) else $error("ready before reset completed");
endmodule : lhp_host
